/* adcm_pkg.sv */
// Purpose: Shared constants for the multiplexed converter control block.
// Assumes: 32-bit APB register bus, 50 MHz system clock.
// Notes:   Register byte offsets are word aligned.
package adcm_pkg;
  localparam int unsigned NUM_CH   = 8;
  localparam int unsigned RES_W    = 12;
  localparam int unsigned AVG_W    = 16;
  localparam int unsigned AVG_N    = 16;
  localparam int unsigned CH_W     = 3;

  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_KIND   = 12'h004;
  localparam logic [11:0] OFS_DIR    = 12'h008;
  localparam logic [11:0] OFS_OLEV   = 12'h00c;
  localparam logic [11:0] OFS_DRV    = 12'h010;
  localparam logic [11:0] OFS_ILEV   = 12'h014;
  localparam logic [11:0] OFS_AUTOEN = 12'h018;
  localparam logic [11:0] OFS_RESULT = 12'h01c;
  localparam logic [11:0] OFS_STATUS = 12'h020;

  localparam int unsigned CTRL_SRST  = 0;
  localparam int unsigned CTRL_AUTO  = 1;
  localparam int unsigned CTRL_AVG   = 2;
  localparam int unsigned CTRL_START = 3;
  localparam int unsigned CTRL_CH_LO = 4;
  localparam int unsigned RES_CH_LO  = 16;
  localparam int unsigned RES_NEW    = 31;
  localparam int unsigned ST_READY   = 0;
  localparam int unsigned ST_BUSY    = 1;

  localparam logic [7:0]  KIND_RST   = 8'h00;
  localparam logic [7:0]  CFG8_RST   = 8'h00;
  localparam logic [11:0] SAR_MID    = 12'h800;

  localparam int unsigned SYS_MHZ    = 50;
  localparam int unsigned T_RST_MS   = 5;
  localparam int unsigned RST_CYC    = T_RST_MS * 1000 * SYS_MHZ;
  localparam int unsigned CNT_W      = 18;
  localparam int unsigned OSC_MHZ    = 80;
  localparam int unsigned T_ACQ_NS   = 400;
  localparam int unsigned ACQ_CYC    = (T_ACQ_NS * OSC_MHZ + 999) / 1000;
  localparam int unsigned T_CYCLE_NS = 1000;
  localparam int unsigned CYCLE_CYC  = (T_CYCLE_NS * OSC_MHZ + 999) / 1000;
  localparam int unsigned STEP_CYC   = 4;

  typedef enum logic [1:0] {CS_IDLE, CS_ACQ, CS_CONV, CS_HOLD} adcm_conv_st_t;
endpackage

/* adcm_ctrl.sv */
// Purpose: Control side of an eight channel 12-bit SAR converter with GPIO.
// Assumes: APB on clk_sys; conversion engine on the converter oscillator.
// Notes:   Multi-bit settings cross by plain double sampling and must be
//          stable before a conversion starts.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - 12-bit conversions, eight channels, up to 1 MSPS
// - Conversion timed from internal oscillator clock
// - Manual start or autonomous scanning mode
// - Reset makes all channels analog inputs
// - Switch closed acquiring, open converting
// - Kind bit set makes channel a GPIO
// - Direction bit picks GPIO input or output
// - Host reads digital input levels
// - Output channels drive written output level; open-drain ones release a high level instead of driving it
// - Driver style bit picks open-drain or push-pull
// - Results are unsigned straight binary codes
// - One code step is supply over 4096
// - Averaging yields a 16-bit result
// - Soft reset completes within 5 ms
// - Soft reset bit clears itself afterwards
// - Output with style 1 is push-pull
// - Input levels show real pin level
module adcm_ctrl #(
  parameter int unsigned RESET_CYCLES = adcm_pkg::RST_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        clk_osc,
  input  wire logic        cmp_above,
  output logic [adcm_pkg::RES_W-1:0] dac_code,
  output logic [adcm_pkg::CH_W-1:0]  mux_sel,
  output logic             mux_connect,
  output logic             sample_switch,
  input  wire logic [adcm_pkg::NUM_CH-1:0] pin_in,
  output logic [adcm_pkg::NUM_CH-1:0]      pin_out,
  output logic [adcm_pkg::NUM_CH-1:0]      pin_oe,
  output logic             dev_ready
);
  import adcm_pkg::*;

  localparam logic [3:0] SEL_NONE = 4'hf;

  // Address decode shared by the read and write paths.
  function automatic logic [3:0] reg_sel(input logic [11:0] a);
    logic [3:0] s;
    s = SEL_NONE;
    if (a == OFS_CTRL) s = 4'h0;
    else if (a == OFS_KIND) s = 4'h1;
    else if (a == OFS_DIR) s = 4'h2;
    else if (a == OFS_OLEV) s = 4'h3;
    else if (a == OFS_DRV) s = 4'h4;
    else if (a == OFS_ILEV) s = 4'h5;
    else if (a == OFS_AUTOEN) s = 4'h6;
    else if (a == OFS_RESULT) s = 4'h7;
    else if (a == OFS_STATUS) s = 4'h8;
    return s;
  endfunction

  // Round robin pick of the next enabled channel after cur.
  function automatic logic [CH_W-1:0] next_ch(input logic [NUM_CH-1:0] m,
                                              input logic [CH_W-1:0] cur);
    logic [CH_W-1:0] c;
    logic            found;
    c = cur;
    found = 1'b0;
    for (int i = 1; i <= NUM_CH; i++) begin
      if (!found && m[CH_W'(cur + CH_W'(i))]) begin
        c = CH_W'(cur + CH_W'(i));
        found = 1'b1;
      end
    end
    return c;
  endfunction

  // ---------------- system clock domain ----------------
  logic              pready_q, pslverr_q;
  logic [31:0]       prdata_q;
  logic [NUM_CH-1:0] kind_q, dir_q, olev_q, drv_q, aen_q;
  logic              auto_q, avg_q, soft_rst_q, rdy_q, busy_q, req_tgl_q;
  logic [CH_W-1:0]   man_ch_q, res_ch_q;
  logic [AVG_W-1:0]  res_q;
  logic              res_new_q, eng_rst_q;
  logic [CNT_W-1:0]  rcnt_q;
  logic [NUM_CH-1:0] pin_s1_q, pin_s2_q, pin_oe_q, pin_out_q;
  logic              ds1_q, ds2_q, ds3_q;
  // Engine results, read here only under the synchronised done toggle.
  logic [AVG_W-1:0]  res_o_q;
  logic [CH_W-1:0]   ch_o_q;
  logic              done_tgl_q;

  logic              access, wr_en, rd_en, done_ev, start_ok;
  logic [3:0]        wsel;
  logic [NUM_CH-1:0] in_lev, out_ch;

  assign access  = psel & penable;
  assign wsel    = reg_sel(paddr);
  assign wr_en   = access & pready_q & pwrite;
  assign rd_en   = access & pready_q & ~pwrite;
  assign done_ev = ds2_q ^ ds3_q;
  assign in_lev  = pin_s2_q & kind_q;
  assign out_ch  = kind_q & dir_q;
  // Manual start refused while busy, in reset, or on a GPIO channel.
  assign start_ok = wr_en && wsel == 4'h0 && pwdata[CTRL_START] &&
                    !pwdata[CTRL_AUTO] && !busy_q && rdy_q &&
                    !kind_q[pwdata[CTRL_CH_LO +: CH_W]];

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access & ~pready_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (access && !pready_q) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= (wsel == SEL_NONE);
      if (!pwrite) begin
        case (wsel)
          4'h0: begin
            prdata_q[CTRL_SRST] <= soft_rst_q;
            prdata_q[CTRL_AUTO] <= auto_q;
            prdata_q[CTRL_AVG]  <= avg_q;
            prdata_q[CTRL_CH_LO +: CH_W] <= man_ch_q;
          end
          4'h1: prdata_q[NUM_CH-1:0] <= kind_q;
          4'h2: prdata_q[NUM_CH-1:0] <= dir_q;
          4'h3: prdata_q[NUM_CH-1:0] <= olev_q;
          4'h4: prdata_q[NUM_CH-1:0] <= drv_q;
          4'h5: prdata_q[NUM_CH-1:0] <= in_lev;
          4'h6: prdata_q[NUM_CH-1:0] <= aen_q;
          4'h7: begin
            prdata_q[AVG_W-1:0] <= res_q;
            prdata_q[RES_CH_LO +: CH_W] <= res_ch_q;
            prdata_q[RES_NEW] <= res_new_q;
          end
          4'h8: begin
            prdata_q[ST_READY] <= rdy_q;
            prdata_q[ST_BUSY]  <= busy_q;
          end
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // Channel configuration returns to all-analog on any reset.
  always_ff @(posedge clk_sys) begin
    if (rst || soft_rst_q) begin
      kind_q   <= KIND_RST;
      dir_q    <= CFG8_RST;
      olev_q   <= CFG8_RST;
      drv_q    <= CFG8_RST;
      aen_q    <= CFG8_RST;
      auto_q   <= 1'b0;
      avg_q    <= 1'b0;
      man_ch_q <= '0;
    end else if (wr_en) begin
      case (wsel)
        4'h0: begin
          auto_q <= pwdata[CTRL_AUTO];
          avg_q  <= pwdata[CTRL_AVG];
          if (!busy_q) begin
            man_ch_q <= pwdata[CTRL_CH_LO +: CH_W];
          end
        end
        4'h1: kind_q <= pwdata[NUM_CH-1:0];
        4'h2: dir_q  <= pwdata[NUM_CH-1:0];
        4'h3: olev_q <= pwdata[NUM_CH-1:0];
        4'h4: drv_q  <= pwdata[NUM_CH-1:0];
        4'h6: aen_q  <= pwdata[NUM_CH-1:0];
        default: ;
      endcase
    end
  end

  // Shared delay counter covers power-up ready time and soft reset.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdy_q      <= 1'b0;
      soft_rst_q <= 1'b0;
      rcnt_q     <= '0;
    end else if (wr_en && wsel == 4'h0 && pwdata[CTRL_SRST]) begin
      rdy_q      <= 1'b0;
      soft_rst_q <= 1'b1;
      rcnt_q     <= '0;
    end else if (!rdy_q) begin
      if (rcnt_q == CNT_W'(RESET_CYCLES - 1)) begin
        rdy_q      <= 1'b1;
        soft_rst_q <= 1'b0;
      end else begin
        rcnt_q <= rcnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      eng_rst_q <= 1'b1;
    end else begin
      eng_rst_q <= ~rdy_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      req_tgl_q <= 1'b0;
      busy_q    <= 1'b0;
    end else if (!rdy_q) begin
      busy_q <= 1'b0;
    end else if (start_ok) begin
      req_tgl_q <= ~req_tgl_q;
      busy_q    <= 1'b1;
    end else if (done_ev) begin
      busy_q <= 1'b0;
    end
  end

  // Result word and its new flag; a fresh result wins over a read clear.
  // The engine holds its result for a whole conversion after toggling,
  // far longer than the toggle takes to cross, so the word is settled.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      res_q     <= '0;
      res_ch_q  <= '0;
      res_new_q <= 1'b0;
    end else if (done_ev) begin
      res_q     <= res_o_q;
      res_ch_q  <= ch_o_q;
      res_new_q <= 1'b1;
    end else if (rd_en && wsel == 4'h7) begin
      res_new_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ds1_q <= 1'b0;
      ds2_q <= 1'b0;
      ds3_q <= 1'b0;
    end else begin
      ds1_q <= done_tgl_q;
      ds2_q <= ds1_q;
      ds3_q <= ds2_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Open-drain pulls low only; push-pull drives both levels.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_oe_q  <= '0;
      pin_out_q <= '0;
    end else begin
      pin_oe_q  <= out_ch & (drv_q | ~olev_q);
      pin_out_q <= out_ch & drv_q & olev_q;
    end
  end

  // ---------------- oscillator clock domain ----------------
  logic              ors1_q, ors2_q;
  logic              rq1_q, rq2_q, rq3_q;
  logic              cs1_q, cs2_q;
  logic [12:0]       cfg1_q, cfg2_q;
  adcm_conv_st_t     st_q;
  logic [CH_W-1:0]   ch_q;
  logic [7:0]        cnt_q;
  logic [3:0]        bit_q, nsmp_q;
  logic [RES_W-1:0]  code_q, smp_q;
  logic [AVG_W-1:0]  acc_q;
  logic              sample_switch_q, conn_q;
  logic              req_ev, o_auto, o_avg;
  logic [NUM_CH-1:0] o_mask;
  logic [CH_W-1:0]   o_man;

  assign req_ev = rq2_q ^ rq3_q;
  assign o_auto = cfg2_q[12];
  assign o_avg  = cfg2_q[11];
  assign o_man  = cfg2_q[10:8];
  assign o_mask = cfg2_q[7:0];

  always_ff @(posedge clk_osc) begin
    ors1_q <= eng_rst_q;
    ors2_q <= ors1_q;
  end

  always_ff @(posedge clk_osc) begin
    if (ors2_q) begin
      rq1_q  <= 1'b0;
      rq2_q  <= 1'b0;
      rq3_q  <= 1'b0;
      cs1_q  <= 1'b0;
      cs2_q  <= 1'b0;
      cfg1_q <= '0;
      cfg2_q <= '0;
    end else begin
      rq1_q  <= req_tgl_q;
      rq2_q  <= rq1_q;
      rq3_q  <= rq2_q;
      cs1_q  <= cmp_above;
      cs2_q  <= cs1_q;
      cfg1_q <= {auto_q, avg_q, man_ch_q, aen_q & ~kind_q};
      cfg2_q <= cfg1_q;
    end
  end

  // SAR engine; every phase except CS_IDLE counts oscillator cycles only.
  always_ff @(posedge clk_osc) begin
    if (ors2_q) begin
      st_q       <= CS_IDLE;
      ch_q       <= '0;
      cnt_q      <= '0;
      bit_q      <= '0;
      nsmp_q     <= '0;
      code_q     <= '0;
      smp_q      <= '0;
      acc_q      <= '0;
      res_o_q    <= '0;
      ch_o_q     <= '0;
      done_tgl_q <= 1'b0;
      sample_switch_q <= 1'b0;
      conn_q     <= 1'b0;
    end else begin
      case (st_q)
        CS_IDLE: begin
          sample_switch_q <= 1'b0;
          conn_q <= 1'b0;
          acc_q  <= '0;
          nsmp_q <= '0;
          cnt_q  <= '0;
          if (o_auto && o_mask != '0) begin
            ch_q <= next_ch(o_mask, ch_q);
            st_q <= CS_ACQ;
          end else if (!o_auto && req_ev) begin
            ch_q <= o_man;
            st_q <= CS_ACQ;
          end
        end
        CS_ACQ: begin
          sample_switch_q <= 1'b1;
          conn_q <= 1'b1;
          cnt_q  <= cnt_q + 8'h01;
          if (cnt_q == 8'(ACQ_CYC - 1)) begin
            sample_switch_q <= 1'b0;
            code_q <= SAR_MID;
            bit_q  <= 4'(RES_W - 1);
            st_q   <= CS_CONV;
          end
        end
        CS_CONV: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q[1:0] == 2'(STEP_CYC - 1)) begin
            // Code step is the supply over 2^12; drop bit if input is below.
            if (!cs2_q) begin
              code_q[bit_q] <= 1'b0;
            end
            if (bit_q == 4'h0) begin
              smp_q <= cs2_q ? code_q : (code_q & ~12'h001);
              st_q  <= CS_HOLD;
            end else begin
              code_q[bit_q - 4'h1] <= 1'b1;
              bit_q <= bit_q - 4'h1;
            end
          end
        end
        CS_HOLD: begin
          conn_q <= 1'b0;
          cnt_q  <= cnt_q + 8'h01;
          // Pads each sample to the 1 us cycle, capping the rate at 1 MSPS.
          if (cnt_q >= 8'(CYCLE_CYC - 1)) begin
            cnt_q <= '0;
            if (o_avg && nsmp_q != 4'(AVG_N - 1)) begin
              acc_q  <= acc_q + AVG_W'(smp_q);
              nsmp_q <= nsmp_q + 4'h1;
              st_q   <= CS_ACQ;
            end else begin
              // Sum of sixteen 12-bit samples fills 16 bits exactly.
              res_o_q    <= o_avg ? acc_q + AVG_W'(smp_q)
                                  : AVG_W'(smp_q);
              ch_o_q     <= ch_q;
              done_tgl_q <= ~done_tgl_q;
              st_q       <= CS_IDLE;
            end
          end
        end
        default: st_q <= CS_IDLE;
      endcase
    end
  end

  assign pready        = pready_q;
  assign prdata        = prdata_q;
  assign pslverr       = pslverr_q;
  assign dac_code      = code_q;
  assign mux_sel       = ch_q;
  assign mux_connect   = conn_q;
  assign sample_switch = sample_switch_q;
  assign pin_out       = pin_out_q;
  assign pin_oe        = pin_oe_q;
  assign dev_ready     = rdy_q;
endmodule // adcm_ctrl

`default_nettype wire

/* adcm_ctrl_chk.sv */
// Purpose: Port-level checks for the converter control block.
// Assumes: Sees only top module ports; rst resets both domains.
// Notes:   Engine checks run on clk_osc, bus and pin checks on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module adcm_ctrl_chk #(
  parameter int unsigned RESET_CYCLES = 20
) (
  input wire logic                         clk_sys,
  input wire logic                         rst,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic                         clk_osc,
  input wire logic [adcm_pkg::CH_W-1:0]    mux_sel,
  input wire logic                         mux_connect,
  input wire logic                         sample_switch,
  input wire logic [adcm_pkg::NUM_CH-1:0]  pin_out,
  input wire logic [adcm_pkg::NUM_CH-1:0]  pin_oe,
  input wire logic                         dev_ready
);
  // Counts cycles without ready; a counter keeps the long delay cheap.
  int unsigned nrdy_q;

  always_ff @(posedge clk_sys) begin
    if (rst || dev_ready) begin
      nrdy_q <= 32'h0;
    end else begin
      nrdy_q <= nrdy_q + 32'h1;
    end
  end

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && !pready;
  endsequence

  wait_state_a: assert property (@(posedge clk_sys) disable iff (rst)
    setup_s |=> access_s ##1 pready) else $error("wait state wrong");
  ready_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
    pready |=> !pready) else $error("ready longer than one cycle");
  err_with_rdy_a: assert property (@(posedge clk_sys) disable iff (rst)
    pslverr |-> pready && psel && penable) else $error("stray error");
  oe_reset_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> pin_oe == 8'h00 && pin_out == 8'h00)
    else $error("pins driven after reset");
  drive_subset_a: assert property (@(posedge clk_sys) disable iff (rst)
    (pin_out & ~pin_oe) == 8'h00) else $error("high level not driven");
  ready_delay_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(dev_ready) |-> nrdy_q == RESET_CYCLES)
    else $error("ready delay wrong");
  switch_conn_a: assert property (@(posedge clk_osc) disable iff (rst)
    sample_switch |-> mux_connect) else $error("switch closed unselected");
  acq_hold_a: assert property (@(posedge clk_osc) disable iff (rst)
    $rose(sample_switch) |-> sample_switch [*8])
    else $error("acquisition too short");
  switch_open_a: assert property (@(posedge clk_osc) disable iff (rst)
    $fell(sample_switch) |-> mux_connect) else $error("no conversion phase");
  gpio_iso_a: assert property (@(posedge clk_osc) disable iff (rst)
    mux_connect |-> !pin_oe[mux_sel]) else $error("driven pin sampled");
endmodule // adcm_ctrl_chk

bind adcm_ctrl adcm_ctrl_chk #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .clk_osc(clk_osc),
  .mux_sel(mux_sel), .mux_connect(mux_connect),
  .sample_switch(sample_switch), .pin_out(pin_out), .pin_oe(pin_oe),
  .dev_ready(dev_ready)
);
`default_nettype wire

/* adcm_far_model.sv */
// Purpose: Analog comparator and pin wiring seen by the control block.
// Assumes: One input level shared by all analog channels.
// Notes:   Released pins read the bench level, standing in for pull-ups.
`timescale 1ns/100ps
`default_nettype none
module adcm_far_model (
  input  wire logic [adcm_pkg::RES_W-1:0]  dac_code,
  input  wire logic [adcm_pkg::NUM_CH-1:0] pin_out,
  input  wire logic [adcm_pkg::NUM_CH-1:0] pin_oe,
  input  wire logic [adcm_pkg::RES_W-1:0]  level,
  input  wire logic [adcm_pkg::NUM_CH-1:0] ext_lvl,
  output logic                             cmp_above,
  output logic [adcm_pkg::NUM_CH-1:0]      pin_in
);
  import adcm_pkg::*;
  // Full scale equals the supply, so code steps are supply over 4096.
  assign cmp_above = (level >= dac_code);
  // A driven pin shows its drive value, a released one the outside level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // adcm_far_model
`default_nettype wire

/* adcm_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the converter control block.
// Assumes: APB master on clk_sys, oscillator on an unrelated 12 ns clock.
// Notes:   Reset delay shortened to RC cycles to keep the run short.
`timescale 1ns/100ps
`default_nettype none
module adcm_ctrl_tb_top;
  import adcm_pkg::*;
  localparam int unsigned RC = 20;
  logic              clk_sys, clk_osc, rst, psel, penable, pwrite;
  logic              pready, pslverr, cmp_above, mux_connect, err;
  logic              sample_switch, dev_ready;
  logic [11:0]       paddr, dac_code, level;
  logic [31:0]       pwdata, prdata, rd;
  logic [CH_W-1:0]   mux_sel;
  logic [NUM_CH-1:0] pin_in, pin_out, pin_oe, ext_lvl;
  int                num_errors, total_checks, cyc;

  adcm_ctrl #(.RESET_CYCLES(RC)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .clk_osc(clk_osc), .cmp_above(cmp_above), .dac_code(dac_code),
    .mux_sel(mux_sel), .mux_connect(mux_connect),
    .sample_switch(sample_switch), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .dev_ready(dev_ready));
  adcm_far_model u_far (.dac_code(dac_code), .pin_out(pin_out),
    .pin_oe(pin_oe), .level(level), .ext_lvl(ext_lvl),
    .cmp_above(cmp_above), .pin_in(pin_in));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    clk_osc = 1'b0;
    #3;
    forever #6 clk_osc = ~clk_osc;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string what, input logic [11:0] a,
                     input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask

  task automatic poll();
    int n = 0;
    rd = 32'h0;
    while (rd[RES_NEW] !== 1'b1 && n < 400) begin
      bus(1'b0, OFS_RESULT, 32'h0);
      n++;
    end
    chk("new_flag", rd[RES_NEW], 1);
  endtask

  task automatic t_reset();
    int n = 0;
    chk("ready_early", dev_ready, 0);
    rdc("kind", OFS_KIND, 32'h0);
    rdc("dir", OFS_DIR, 32'h0);
    rdc("drv", OFS_DRV, 32'h0);
    while (dev_ready !== 1'b1 && n < RC + 10) begin
      @(posedge clk_sys);
      n++;
    end
    chk("ready_up", dev_ready, 1);
    rdc("status", OFS_STATUS, 32'h1);
    bus(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", err, 1);
  endtask

  task automatic t_gpio(input logic [7:0] k, dr, ol, dv, ex);
    logic [7:0] oe, po;
    ext_lvl <= ex;
    bus(1'b1, OFS_KIND, {24'h0, k});
    bus(1'b1, OFS_DIR, {24'h0, dr});
    bus(1'b1, OFS_OLEV, {24'h0, ol});
    bus(1'b1, OFS_DRV, {24'h0, dv});
    repeat (3) @(posedge clk_sys);
    // Open-drain outputs drive only a low; a high is left released.
    oe = k & dr & (dv | ~ol);
    po = k & dr & dv & ol;
    chk("pin_oe", pin_oe, oe);
    chk("pin_out", pin_out, po);
    rdc("in_lvl", OFS_ILEV, k & (po | (~oe & ex)));
  endtask

  task automatic t_conv(input logic [2:0] ch, input logic [11:0] lv,
                        input logic avg);
    logic [31:0] c;
    c = (32'(ch) << CTRL_CH_LO) | (32'(avg) << CTRL_AVG);
    level <= lv;
    bus(1'b1, OFS_CTRL, c);
    bus(1'b1, OFS_CTRL, c | 32'h8);
    rdc("busy", OFS_STATUS, 32'h3);
    poll();
    chk("result", rd[15:0], avg ? {lv, 4'h0} : {4'h0, lv});
    chk("res_ch", rd[18:16], ch);
  endtask

  task automatic t_refuse();
    bus(1'b1, OFS_CTRL, 32'h60);
    bus(1'b1, OFS_CTRL, 32'h68);
    repeat (200) @(posedge clk_sys);
    bus(1'b0, OFS_RESULT, 32'h0);
    chk("gpio_start", rd[RES_NEW], 0);
  endtask

  task automatic t_auto();
    level <= 12'h3c5;
    bus(1'b1, OFS_AUTOEN, 32'h14);
    bus(1'b1, OFS_CTRL, 32'h2);
    poll();
    chk("auto_ch", rd[18:16], 2);
    chk("auto_res", rd[15:0], 16'h03c5);
    bus(1'b1, OFS_CTRL, 32'h0);
    repeat (100) @(posedge clk_sys);
  endtask

  task automatic t_srst();
    int t0, n;
    bus(1'b1, OFS_CTRL, 32'h1);
    t0 = cyc;
    rdc("srst_set", OFS_CTRL, 32'h1);
    n = 0;
    while (rd[CTRL_SRST] !== 1'b0 && n < 40) begin
      bus(1'b0, OFS_CTRL, 32'h0);
      n++;
    end
    chk("srst_clear", rd[CTRL_SRST], 0);
    chk("srst_time", cyc - t0 <= RC + 12, 1);
    rdc("kind_srst", OFS_KIND, 32'h0);
    chk("oe_srst", pin_oe, 8'h00);
  endtask

  initial begin
    logic [11:0] lvs [4];
    lvs = '{12'h000, 12'h801, 12'hfff, 12'h5a3};
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    level = 12'h000;
    ext_lvl = 8'h00;
    // The engine stays in reset until the ready delay ends, so two edges do.
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_gpio(8'hf0, 8'hc0, 8'ha0, 8'h40, 8'h3a);
    t_gpio(8'hf0, 8'hc0, 8'h60, 8'h40, 8'h25);
    foreach (lvs[i]) begin
      t_conv(3'(i), lvs[i], 1'b0);
    end
    t_conv(3'd1, 12'hfff, 1'b1);
    t_refuse();
    t_auto();
    t_srst();
    give_verdict();
  end
endmodule // adcm_ctrl_tb_top
`default_nettype wire
